// ===== bench/spgc_monitor.sv
// Purpose: link checker for the generator/checker stream pair
// Assumes: both ends on pclk, presetn async active low
// Notes:   helper follows packet position on the card_to_host side
`timescale 1ns/1ps
`default_nettype none
module spgc_monitor
    import spgc_pkg::*;
(
    // clock and reset
    input wire logic                        pclk,
    input wire logic                        presetn,
    // host_to_card
    input wire logic                        h2c_tvalid,
    input wire logic                        h2c_tready,
    input wire logic [spgc_pkg::DATA_W-1:0] h2c_tdata,
    input wire logic                        h2c_tlast,
    // card_to_host
    input wire logic                        c2s_tvalid,
    input wire logic                        c2s_tready,
    input wire logic [spgc_pkg::DATA_W-1:0] c2s_tdata,
    input wire logic                        c2s_tlast
);
    import spgc_pkg::*;
    typedef struct packed {logic first; logic [15:0] tag; logic [15:0] len; logic [11:0] cnt;}
        spgc_mon_t;
    spgc_mon_t   st_ff;
    spgc_mon_t   nxt_st;
    logic [16:0] cur_len;
    logic [12:0] cur_idx;
    logic [12:0] cur_nb;
    always_comb
    begin
        nxt_st = st_ff;
        cur_len = st_ff.first ? {1'b0, c2s_tdata[15:0]} : {1'b0, st_ff.len};
        cur_idx = st_ff.first ? 13'h0 : {1'b0, st_ff.cnt};
        cur_nb = (cur_len == 17'h0) ? 13'h1 : 13'((cur_len + 17'hf) >> 4);
        if (c2s_tvalid && c2s_tready)
        begin
            nxt_st.first = c2s_tlast;
            nxt_st.tag = c2s_tdata[127:112];
            nxt_st.len = cur_len[15:0];
            nxt_st.cnt = cur_idx[11:0] + 12'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            st_ff <= '{first: 1'b1, default: '0};
        else
            st_ff <= nxt_st;
    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_C2S_HOLD: assert property (c2s_tvalid && !c2s_tready |=> c2s_tvalid
        && $stable(c2s_tdata) && $stable(c2s_tlast)) else $error("c2s beat changed");
    AST_H2C_HOLD: assert property (h2c_tvalid && !h2c_tready |=> h2c_tvalid
        && $stable(h2c_tdata) && $stable(h2c_tlast)) else $error("h2c beat changed");
    AST_C2S_LANES: assert property (c2s_tvalid |->
        c2s_tdata[127:16] == {7{c2s_tdata[127:112]}}) else $error("tag lanes differ");
    AST_C2S_BODY: assert property (c2s_tvalid && !st_ff.first |->
        c2s_tdata[15:0] == c2s_tdata[127:112]) else $error("lane0 not tag");
    AST_C2S_TAG: assert property (c2s_tvalid && !st_ff.first |->
        c2s_tdata[127:112] == st_ff.tag) else $error("tag changed in packet");
    AST_C2S_LAST: assert property (c2s_tvalid |->
        c2s_tlast == (cur_idx + 13'h1 == cur_nb)) else $error("tlast misplaced");
    AST_H2C_GAP: assert property (h2c_tvalid && h2c_tready |=> !h2c_tvalid)
        else $error("h2c slice refilled at once");
    AST_C2S_RDY: assert property (c2s_tvalid && c2s_tready |=> !c2s_tready)
        else $error("c2s slice ready while full");
    cover property (c2s_tvalid && c2s_tready && c2s_tlast);
    cover property (h2c_tvalid && h2c_tready && h2c_tlast);
    cover property (c2s_tvalid && !c2s_tready ##1 c2s_tready);
endmodule
`default_nettype wire

// ===== bench/spgc_tb.sv
// Purpose: self-checking bench for the generator/checker pair over the stream link
// Assumes: pclk 250 MHz, apb answers after a wait state
// Notes:   outbound beats and the mismatch flag come from spgc_dev and are checked against a bench model
`timescale 1ns/1ps
`default_nettype none
module spgc_tb;
    import spgc_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready, pslverr, data_mismatch, irq, er;
    logic         u_h2c_tvalid = 1'b0, u_h2c_tlast = 1'b0, u_c2s_tready = 1'b0;
    logic [127:0] u_h2c_tdata = '0, u_c2s_tdata;
    logic         u_h2c_tready, u_c2s_tvalid, u_c2s_tlast;
    logic [15:0]  lfsr_ff = 16'h0038;
    logic [128:0] loop_q[$];
    logic [31:0]  rd;
    logic         exp_mm = 1'b0;
    int           fails = 0, tests_run = 0, cyc = 0, mode = 0, glen = 33;
    int           gtag = 0, gidx = 0, gpkts = 0, ctag = 0, wrap = 2;
    spgc_if link ();
    spgc_dev spgc_dev_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .data_mismatch, .irq, .link(link));
    spgc_dma spgc_dma_i (.pclk, .presetn, .link(link), .u_h2c_tvalid, .u_h2c_tdata,
        .u_h2c_tlast, .u_h2c_tready, .u_c2s_tvalid, .u_c2s_tdata, .u_c2s_tlast, .u_c2s_tready);
    spgc_monitor spgc_monitor_i (.pclk, .presetn, .h2c_tvalid(link.h2c_tvalid),
        .h2c_tready(link.h2c_tready), .h2c_tdata(link.h2c_tdata), .h2c_tlast(link.h2c_tlast),
        .c2s_tvalid(link.c2s_tvalid), .c2s_tready(link.c2s_tready),
        .c2s_tdata(link.c2s_tdata), .c2s_tlast(link.c2s_tlast));
    always #2 pclk = ~pclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_beat(input string n, input logic [128:0] e, input logic [128:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [127:0] pat(input int len, input int tag, input int idx);
        logic [127:0] b;
        b = {8{tag[15:0]}};
        if (idx == 0)
            b[15:0] = len[15:0];
        return b;
    endfunction
    function automatic int nbeats(input int len);
        return (len == 0) ? 1 : (len + 15) / 16;
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // ready toggles at random so the card_to_host slice sees back-pressure; host_to_card back-pressure reaches it only in loopback
    always @(posedge pclk)
    begin
        lfsr_ff <= lfsr_next(lfsr_ff);
        u_c2s_tready <= lfsr_ff[0] | lfsr_ff[3];
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fails++;
            conclude();
        end
    end
    always @(posedge pclk)
        if (u_c2s_tvalid && u_c2s_tready)
        begin
            if (mode == 2)
                chk_beat("loop beat", (loop_q.size() > 0) ? loop_q.pop_front() : {129{1'bx}},
                    {u_c2s_tlast, u_c2s_tdata});
            else
            begin
                chk_beat("gen beat", {1'(gidx + 1 == nbeats(glen)), pat(glen, gtag, gidx)},
                    {u_c2s_tlast, u_c2s_tdata});
                gidx++;
                if (gidx == nbeats(glen))
                begin
                    gidx = 0;
                    gpkts++;
                    gtag = (gtag == wrap) ? 0 : gtag + 1;
                end
            end
        end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_reg(n, e, rd);
    endtask
    task automatic send(input int len, input int tag, input logic bad);
        int           n;
        logic [127:0] b;
        n = nbeats(len);
        for (int i = 0; i < n; i++)
        begin
            b = pat(len, tag, i) ^ {bad && i == n - 1, 127'h0};
            u_h2c_tvalid <= 1'b1;
            u_h2c_tdata <= b;
            u_h2c_tlast <= (i == n - 1);
            if (mode == 2)
                loop_q.push_back({1'(i == n - 1), b});
            @(posedge pclk);
            while (u_h2c_tready !== 1'b1)
                @(posedge pclk);
        end
        if (mode != 2)
        begin
            exp_mm = exp_mm | bad | (tag != ctag);
            ctag = (ctag == wrap) ? 0 : ctag + 1;
        end
        u_h2c_tvalid <= 1'b0;
        u_h2c_tdata <= ~b;
        @(posedge pclk);
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("ctrl", REG_CTRL, 32'h0);
        rdchk("len", REG_LEN, 32'h40);
        rdchk("wrap", REG_WRAP, 32'hffff);
        rdchk("mask", REG_MASK, 32'h0);
        rdchk("unmapped", 8'h14, 32'h0);
        chk_reg("slverr", 32'h1, {31'h0, er});
        mode = 1;
        apb(1'b1, REG_LEN, 32'h21);
        apb(1'b1, REG_WRAP, 32'h2);
        apb(1'b1, REG_CTRL, 32'h1);
        while (gpkts < 8)
            @(posedge pclk);
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (60) @(posedge pclk);
        chk_reg("gen idle", 32'h0, 32'(gidx));
        rdchk("stat gen", REG_STAT, 32'h2);
        apb(1'b1, REG_STAT, 32'h7);
        apb(1'b1, REG_MASK, 32'h1);
        apb(1'b1, REG_CTRL, 32'h2);
        for (int p = 0; p < 5; p++)
        begin
            send(33, p % 3, p == 4);
            repeat (4) @(posedge pclk);
            chk_reg("mismatch", {31'h0, exp_mm}, {31'h0, data_mismatch});
            chk_reg("irq", {31'h0, exp_mm}, {31'h0, irq});
        end
        rdchk("stat chk", REG_STAT, 32'h5);
        chk_reg("sticky", 32'h1, {31'h0, data_mismatch});
        apb(1'b1, REG_STAT, 32'h1);
        exp_mm = 1'b0;
        chk_reg("cleared", 32'h0, {31'h0, data_mismatch});
        mode = 2;
        apb(1'b1, REG_CTRL, 32'h6);
        for (int p = 0; p < 3; p++)
            send(p * 16, 16'h5a + p, 1'b0);
        repeat (20) @(posedge pclk);
        chk_reg("loop left", 32'h0, 32'(loop_q.size()));
        chk_reg("loop mismatch", 32'h0, {31'h0, data_mismatch});
        // generator and checker together; disabling the checker drops the error
        gtag = 0;
        gpkts = 0;
        ctag = 0;
        mode = 1;
        apb(1'b1, REG_CTRL, 32'h3);
        send(33, 0, 1'b0);
        send(33, 1, 1'b1);
        repeat (4) @(posedge pclk);
        chk_reg("both mismatch", {31'h0, exp_mm}, {31'h0, data_mismatch});
        while (gpkts < 2)
            @(posedge pclk);
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (60) @(posedge pclk);
        chk_reg("both gen idle", 32'h0, 32'(gidx));
        chk_reg("disabled", 32'h0, {31'h0, data_mismatch});
        conclude();
    end
endmodule
`default_nettype wire

// ===== core/spgc_dev.sv
// Purpose: packet generator, checker and loopback on the dma streams
// Assumes: one clock pclk at 250 MHz, apb control port
// Notes:   length field counts bytes; a packet spans ceil(len/16) beats, at least one
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spgc_dev
    import spgc_pkg::*;
#(
    parameter int DATA_W_P = spgc_pkg::DATA_W
)
(
    // clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // apb control port
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [spgc_pkg::APB_AW-1:0]  paddr,
    input  wire logic [spgc_pkg::APB_DW-1:0]  pwdata,
    output var  logic [spgc_pkg::APB_DW-1:0]  prdata,
    output var  logic                         pready,
    output var  logic                         pslverr,
    // status outputs
    output var  logic                         data_mismatch,
    output var  logic                         irq,
    // link
    spgc_if.dev                               link
);
    import spgc_pkg::*;

    localparam int LANES = DATA_W / LANE_W;

    generate
        if (DATA_W_P != DATA_W)
        begin : g_bad_width
            $error("spgc_dev: only the 128-bit stream width is supported");
        end
    endgenerate

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [15:0]       len;
        logic [15:0]       wrap;
        logic [ST_W-1:0]   stat;
        logic [ST_W-1:0]   mask;
        logic              irq;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              h_rdy;
        logic              c_vld;
        logic [DATA_W-1:0] c_data;
        logic              c_last;
        logic              g_sof;
        logic [CNT_W-1:0]  g_beat;
        logic [15:0]       g_tag;
        logic              k_sof;
        logic [CNT_W-1:0]  k_beat;
        logic [15:0]       k_tag;
    } spgc_dev_st_t;

    spgc_dev_st_t st_ff;
    spgc_dev_st_t nxt_st;

    always_comb
    begin
        logic              loop_on;
        logic              chk_on;
        logic              acc;
        logic              c_free;
        logic              bad;
        logic [CNT_W-1:0]  last_beat;
        logic [16:0]       len_sum;
        logic [ST_W-1:0]   ev;
        logic              wr;
        logic              rd;
        loop_on   = st_ff.ctrl[CTRL_LOOP];
        chk_on    = st_ff.ctrl[CTRL_CHK] && !loop_on;
        acc       = link.h2c_tvalid && st_ff.h_rdy;
        c_free    = !st_ff.c_vld || link.c2s_tready;
        bad       = 1'b0;
        ev        = '0;
        wr        = psel && penable && st_ff.pready && pwrite;
        rd        = psel && penable && !st_ff.pready && !pwrite;
        nxt_st    = st_ff;
        // beats per packet from the byte length, never below one
        len_sum   = {1'b0, st_ff.len} + 17'(BEAT_BYTES - 1);
        last_beat = (st_ff.len == 16'h0000) ? '0
                  : CNT_W'((len_sum >> BEAT_SHIFT) - 17'h00001);

        if (st_ff.c_vld && link.c2s_tready)
        begin
            nxt_st.c_vld = 1'b0;
        end

        if (loop_on)
        begin
            // every inbound beat passes unchanged, tlast included
            if (acc)
            begin
                nxt_st.c_vld  = 1'b1;
                nxt_st.c_data = link.h2c_tdata;
                nxt_st.c_last = link.h2c_tlast;
            end
        end
        else if ((st_ff.ctrl[CTRL_GEN] || !st_ff.g_sof) && c_free)
        begin
            // a packet once started is finished even if the enable drops
            nxt_st.c_vld = 1'b1;
            for (int i = 0; i < LANES; i++)
            begin
                nxt_st.c_data[i*LANE_W +: LANE_W] = st_ff.g_tag;
            end
            if (st_ff.g_sof)
            begin
                nxt_st.c_data[LANE_W-1:0] = st_ff.len;
            end
            nxt_st.c_last = (st_ff.g_beat == last_beat);
            if (st_ff.g_beat == last_beat)
            begin
                nxt_st.g_sof  = 1'b1;
                nxt_st.g_beat = '0;
                nxt_st.g_tag  = (st_ff.g_tag == st_ff.wrap) ? 16'h0000
                              : st_ff.g_tag + 16'h0001;
                ev[ST_GEN_PKT] = 1'b1;
            end
            else
            begin
                nxt_st.g_sof  = 1'b0;
                nxt_st.g_beat = st_ff.g_beat + CNT_W'(1);
            end
        end
        else if (!st_ff.ctrl[CTRL_GEN] && st_ff.g_sof)
        begin
            // idle generator starts the next run from tag zero
            nxt_st.g_tag = 16'h0000;
        end

        if (!chk_on)
        begin
            nxt_st.k_sof  = 1'b1;
            nxt_st.k_beat = '0;
            nxt_st.k_tag  = 16'h0000;
        end
        else if (acc)
        begin
            // byte-exact compare of every lane, position of tlast included
            for (int i = 0; i < LANES; i++)
            begin
                if (i == 0 && st_ff.k_sof)
                begin
                    bad = bad || (link.h2c_tdata[LANE_W-1:0] != st_ff.len);
                end
                else
                begin
                    bad = bad || (link.h2c_tdata[i*LANE_W +: LANE_W] != st_ff.k_tag);
                end
            end
            bad = bad || (link.h2c_tlast != (st_ff.k_beat == last_beat));
            ev[ST_MISMATCH] = bad;
            if (link.h2c_tlast)
            begin
                // next accepted beat opens a packet
                nxt_st.k_sof  = 1'b1;
                nxt_st.k_beat = '0;
                nxt_st.k_tag  = (st_ff.k_tag == st_ff.wrap) ? 16'h0000
                              : st_ff.k_tag + 16'h0001;
                ev[ST_CHK_PKT] = 1'b1;
            end
            else
            begin
                nxt_st.k_sof  = 1'b0;
                nxt_st.k_beat = st_ff.k_beat + CNT_W'(1);
            end
        end

        // apb: pready comes one cycle into the access phase
        nxt_st.pready  = psel && penable && !st_ff.pready;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = '0;
        if (psel && penable && !st_ff.pready)
        begin
            unique case (paddr)
                REG_CTRL: nxt_st.prdata = 32'(st_ff.ctrl);
                REG_LEN:  nxt_st.prdata = 32'(st_ff.len);
                REG_WRAP: nxt_st.prdata = 32'(st_ff.wrap);
                REG_STAT: nxt_st.prdata = 32'(st_ff.stat);
                REG_MASK: nxt_st.prdata = 32'(st_ff.mask);
                default:  nxt_st.pslverr = 1'b1;
            endcase
            if (!rd)
            begin
                nxt_st.prdata = '0;
            end
        end
        if (wr)
        begin
            unique case (paddr)
                REG_CTRL: nxt_st.ctrl = pwdata[CTRL_W-1:0];
                REG_LEN:  nxt_st.len  = pwdata[15:0];
                REG_WRAP: nxt_st.wrap = pwdata[15:0];
                REG_STAT: nxt_st.stat = st_ff.stat & ~pwdata[ST_W-1:0];
                REG_MASK: nxt_st.mask = pwdata[ST_W-1:0];
                default:  nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        // set wins over the write-one clear; a disabled checker drops the error
        nxt_st.stat = nxt_st.stat | ev;
        if (!chk_on)
        begin
            nxt_st.stat[ST_MISMATCH] = 1'b0;
        end
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
        // ready follows the mode of the next cycle, so entering loopback never
        // overwrites a generated beat still waiting; outside loopback always drained
        nxt_st.h_rdy = nxt_st.ctrl[CTRL_LOOP] ? !nxt_st.c_vld : 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff       <= '0;
            st_ff.ctrl  <= CTRL_RST;
            st_ff.len   <= LEN_RST;
            st_ff.wrap  <= WRAP_RST;
            st_ff.mask  <= MASK_RST;
            st_ff.h_rdy <= 1'b1;
            st_ff.g_sof <= 1'b1;
            st_ff.k_sof <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata          = st_ff.prdata;
    assign pready          = st_ff.pready;
    assign pslverr         = st_ff.pslverr;
    assign data_mismatch   = st_ff.stat[ST_MISMATCH];
    assign irq             = st_ff.irq;
    assign link.h2c_tready = st_ff.h_rdy;
    assign link.c2s_tvalid = st_ff.c_vld;
    assign link.c2s_tdata  = st_ff.c_data;
    assign link.c2s_tlast  = st_ff.c_last;
endmodule
`default_nettype wire

// ===== core/spgc_dma.sv
// Purpose: dma-side end, one register slice per direction between user ports and the link
// Assumes: user side on pclk; every beat handed over unchanged including tlast
// Notes:   slices run at half rate so that every output comes from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module spgc_dma
    import spgc_pkg::*;
(
    // clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // link
    spgc_if.dma                               link,
    // host_to_card beats from the dma user
    input  wire logic                         u_h2c_tvalid,
    input  wire logic [spgc_pkg::DATA_W-1:0]  u_h2c_tdata,
    input  wire logic                         u_h2c_tlast,
    output var  logic                         u_h2c_tready,
    // card_to_host beats to the dma user
    output var  logic                         u_c2s_tvalid,
    output var  logic [spgc_pkg::DATA_W-1:0]  u_c2s_tdata,
    output var  logic                         u_c2s_tlast,
    input  wire logic                         u_c2s_tready
);
    import spgc_pkg::*;

    typedef struct packed {
        logic              h_vld;
        logic [DATA_W-1:0] h_data;
        logic              h_last;
        logic              h_rdy;
        logic              c_vld;
        logic [DATA_W-1:0] c_data;
        logic              c_last;
        logic              c_rdy;
    } spgc_dma_st_t;

    spgc_dma_st_t st_ff;
    spgc_dma_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        // host_to_card slice: a held beat stays until the block takes it
        if (st_ff.h_vld && link.h2c_tready)
        begin
            nxt_st.h_vld = 1'b0;
        end
        if (u_h2c_tvalid && st_ff.h_rdy)
        begin
            nxt_st.h_vld  = 1'b1;
            nxt_st.h_data = u_h2c_tdata;
            nxt_st.h_last = u_h2c_tlast;
        end
        nxt_st.h_rdy = !nxt_st.h_vld;
        // card_to_host slice
        if (st_ff.c_vld && u_c2s_tready)
        begin
            nxt_st.c_vld = 1'b0;
        end
        if (link.c2s_tvalid && st_ff.c_rdy)
        begin
            nxt_st.c_vld  = 1'b1;
            nxt_st.c_data = link.c2s_tdata;
            nxt_st.c_last = link.c2s_tlast;
        end
        nxt_st.c_rdy = !nxt_st.c_vld;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign link.h2c_tvalid = st_ff.h_vld;
    assign link.h2c_tdata  = st_ff.h_data;
    assign link.h2c_tlast  = st_ff.h_last;
    assign link.c2s_tready = st_ff.c_rdy;
    assign u_h2c_tready    = st_ff.h_rdy;
    assign u_c2s_tvalid    = st_ff.c_vld;
    assign u_c2s_tdata     = st_ff.c_data;
    assign u_c2s_tlast     = st_ff.c_last;
endmodule
`default_nettype wire

// ===== core/spgc_if.sv
// Purpose: stream link between the dma engine end and the generator/checker end
// Assumes: both ends on pclk
// Notes:   axi4-stream valid/ready, tlast closes a packet
`timescale 1ns/1ps
`default_nettype none
interface spgc_if;
    // host_to_card: dma end drives the beats
    logic                         h2c_tvalid;
    logic                         h2c_tready;
    logic [spgc_pkg::DATA_W-1:0]  h2c_tdata;
    logic                         h2c_tlast;
    // card_to_host: block end drives the beats
    logic                         c2s_tvalid;
    logic                         c2s_tready;
    logic [spgc_pkg::DATA_W-1:0]  c2s_tdata;
    logic                         c2s_tlast;

    modport dma
    (
        output h2c_tvalid, h2c_tdata, h2c_tlast,
        input  h2c_tready,
        input  c2s_tvalid, c2s_tdata, c2s_tlast,
        output c2s_tready
    );
    modport dev
    (
        input  h2c_tvalid, h2c_tdata, h2c_tlast,
        output h2c_tready,
        output c2s_tvalid, c2s_tdata, c2s_tlast,
        input  c2s_tready
    );
endinterface
`default_nettype wire

// ===== core/spgc_pkg.sv
// Purpose: shared constants for the stream packet generator/checker and its dma-side end
// Assumes: 128-bit beats on the 250 MHz stream clock, 32-bit apb control port
// Notes:   register offsets are byte addresses of aligned words
package spgc_pkg;
    localparam int          DATA_W      = 128;
    localparam int          LANE_W      = 16;
    localparam int          BEAT_BYTES  = DATA_W / 8;
    localparam int          BEAT_SHIFT  = 4;
    localparam int          CNT_W       = 12;
    localparam int          APB_AW      = 8;
    localparam int          APB_DW      = 32;
    // register map
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_LEN     = 8'h04;
    localparam logic [7:0]  REG_WRAP    = 8'h08;
    localparam logic [7:0]  REG_STAT    = 8'h0c;
    localparam logic [7:0]  REG_MASK    = 8'h10;
    // control bits
    localparam int          CTRL_GEN    = 0;
    localparam int          CTRL_CHK    = 1;
    localparam int          CTRL_LOOP   = 2;
    localparam int          CTRL_W      = 3;
    // status / mask bits
    localparam int          ST_MISMATCH = 0;
    localparam int          ST_GEN_PKT  = 1;
    localparam int          ST_CHK_PKT  = 2;
    localparam int          ST_W        = 3;
    // reset values
    localparam logic [2:0]  CTRL_RST    = 3'h0;
    localparam logic [15:0] LEN_RST     = 16'h0040;
    localparam logic [15:0] WRAP_RST    = 16'hffff;
    localparam logic [2:0]  MASK_RST    = 3'h0;
endpackage
